//--- design/pin_share_consts.svh
// constants for the test-pin sharing and probe block
// How it works
// RULE1: flexible mode, test mode select low switches shared pins to boundary scan.
// RULE2: shared pins stay in scan use until the test state machine enters reset.
// RULE3: five test clocks with mode select high reach the reset state.
// RULE4: test reset low holds the state machine in reset; scan is unavailable.
// RULE5: dedicated mode keeps the three shared pins for boundary scan only.
// RULE6: dedicated mode, mode select drives the standard state machine, not sharing.
// RULE7: two probe outputs present any selected internal node in real time; the code registers them, so they follow one core clock late.
// RULE8: with debugging finished each probe pin acts as an ordinary user pin.
// RULE9: one-time fuse picks the mode; unprogrammed fuse means flexible mode.
// RULE10: in user function, the scan logic ignores the pin except mode select.
`ifndef PIN_SHARE_CONSTS_SVH
`define PIN_SHARE_CONSTS_SVH

// shared pin lanes
`define PIN_TCK 0
`define PIN_TDI 1
`define PIN_TDO 2
`define PIN_N   3

// synchroniser lanes
`define SY_TCK  0
`define SY_TDI  1
`define SY_TMS  2
`define SY_TRST 3
`define SY_FUSE 4
`define SY_N    5
`define SY_RST  5'h04

// probe node selection
`define NODE_W  16
`define SEL_W   4

// consecutive test clocks with mode select high that force reset
`define RESET_TCKS 3'h5
`define CNT_MAX    3'h7

`endif

//--- design/pin_share_ctrl.sv
// test-pin sharing control, test state machine and two diagnostic probes
`timescale 1ns/10ps
`default_nettype none
`include "pin_share_consts.svh"

module pin_share_ctrl (
    // clock, reset, enable
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // test pins from the tester, and the mode fuse
    input  wire logic                tms_pin,
    input  wire logic                trst_n_pin,
    input  wire logic                fuse_blown,
    // shared pins: tck, tdi, tdo lanes
    input  wire logic [`PIN_N-1:0]   pin_in,
    output logic      [`PIN_N-1:0]   pin_out,
    output logic      [`PIN_N-1:0]   pin_oe,
    // user side of the shared pins
    input  wire logic [`PIN_N-1:0]   user_out,
    input  wire logic [`PIN_N-1:0]   user_oe,
    output logic      [`PIN_N-1:0]   user_in,
    // status
    output logic                     scan_active,
    output pin_share_pkg::tap_state_t tap_state,
    // probes
    input  wire logic [`NODE_W-1:0]  probe_nodes,
    input  wire logic [`SEL_W-1:0]   probe_sel_a,
    input  wire logic [`SEL_W-1:0]   probe_sel_b,
    input  wire logic                debug_en,
    input  wire logic [1:0]          user_probe_out,
    input  wire logic [1:0]          user_probe_oe,
    output logic                     probe_out_a,
    output logic                     probe_out_b,
    output logic      [1:0]          probe_oe
);
    import pin_share_pkg::*;

    // standard test state machine step
    function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
        tap_state_t n;
        n = tap_reset;
        unique case (s)
            tap_reset:    n = tms ? tap_reset  : tap_idle;
            tap_idle:     n = tms ? tap_sel_dr : tap_idle;
            tap_sel_dr:   n = tms ? tap_sel_ir : tap_cap_dr;
            tap_cap_dr:   n = tms ? tap_ex1_dr : tap_shift_dr;
            tap_shift_dr: n = tms ? tap_ex1_dr : tap_shift_dr;
            tap_ex1_dr:   n = tms ? tap_upd_dr : tap_pause_dr;
            tap_pause_dr: n = tms ? tap_ex2_dr : tap_pause_dr;
            tap_ex2_dr:   n = tms ? tap_upd_dr : tap_shift_dr;
            tap_upd_dr:   n = tms ? tap_sel_dr : tap_idle;
            tap_sel_ir:   n = tms ? tap_reset  : tap_cap_ir;
            tap_cap_ir:   n = tms ? tap_ex1_ir : tap_shift_ir;
            tap_shift_ir: n = tms ? tap_ex1_ir : tap_shift_ir;
            tap_ex1_ir:   n = tms ? tap_upd_ir : tap_pause_ir;
            tap_pause_ir: n = tms ? tap_ex2_ir : tap_pause_ir;
            tap_ex2_ir:   n = tms ? tap_upd_ir : tap_shift_ir;
            tap_upd_ir:   n = tms ? tap_sel_dr : tap_idle;
            default:      n = tap_reset;
        endcase
        return n;
    endfunction

    // synchronisers and tck edge history
    logic [`SY_N-1:0] sy1_q, sy2_q;
    logic             tck_hist_q;
    logic [1:0]       warm_q;
    logic [`SY_N-1:0] sy_raw;
    logic             tck_s, tdi_s, tms_s, trst_s, dedicated;
    logic             tck_rise, tck_fall;

    always_comb begin
        sy_raw           = '0;
        sy_raw[`SY_TCK]  = pin_in[`PIN_TCK];
        sy_raw[`SY_TDI]  = pin_in[`PIN_TDI];
        sy_raw[`SY_TMS]  = tms_pin;
        sy_raw[`SY_TRST] = trst_n_pin;
        sy_raw[`SY_FUSE] = fuse_blown;
    end

    // two flops per outside input, plus one for edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_q      <= `SY_RST;
            sy2_q      <= `SY_RST;
            tck_hist_q <= 1'b0;
            warm_q     <= '0;
        end else if (clk_en) begin
            sy1_q      <= sy_raw;
            sy2_q      <= sy1_q;
            tck_hist_q <= sy2_q[`SY_TCK];
            warm_q     <= {warm_q[0], 1'b1};   // fuse lane valid once the chain has filled
        end
    end

    assign tck_s     = sy2_q[`SY_TCK];
    assign tdi_s     = sy2_q[`SY_TDI];
    assign tms_s     = sy2_q[`SY_TMS];
    assign trst_s    = sy2_q[`SY_TRST];
    assign dedicated = sy2_q[`SY_FUSE];   // fuse unprogrammed reads 0: flexible
    assign tck_rise  = tck_s & ~tck_hist_q;
    assign tck_fall  = ~tck_s & tck_hist_q;

    // state machine, sharing flag and scan path
    tap_state_t tap_q, tap_d;
    logic       active_q, active_d;
    logic       bypass_q, bypass_d;
    logic       tdo_q, tdo_d;
    logic       tdo_oe_q, tdo_oe_d;
    logic       shifting;
    logic       clk_ok;

    assign shifting = (tap_q == tap_shift_dr) || (tap_q == tap_shift_ir);
    assign clk_ok   = active_q || dedicated;

    always_comb begin
        tap_d    = tap_q;
        active_d = active_q;
        bypass_d = bypass_q;
        tdo_d    = tdo_q;
        tdo_oe_d = tdo_oe_q;
        if (!trst_s) begin
            tap_d = tap_reset;                                  // RULE4
        end else if (clk_ok && tck_rise) begin
            tap_d = tap_next(tap_q, tms_s);                     // RULE3 RULE6 RULE10
            if (tap_q == tap_cap_dr || tap_q == tap_cap_ir)
                bypass_d = 1'b0;
            else if (shifting)
                bypass_d = tdi_s;
        end
        if (clk_ok && tck_fall) begin
            tdo_d    = bypass_q;
            tdo_oe_d = shifting;
        end
        if (!clk_ok || !trst_s)
            tdo_oe_d = 1'b0;
        if (dedicated) begin
            active_d = 1'b1;                                    // RULE5 RULE6
        end else if (!active_q) begin
            active_d = !tms_s && trst_s;                        // RULE1 RULE9
        end else if (tap_d == tap_reset && (tap_q != tap_reset || tck_rise)) begin
            active_d = 1'b0;                                    // RULE2
        end else if (!trst_s) begin
            active_d = 1'b0;                                    // RULE4
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_q    <= tap_reset;
            active_q <= 1'b0;
            bypass_q <= 1'b0;
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (clk_en) begin
            tap_q    <= tap_d;
            active_q <= active_d;
            bypass_q <= bypass_d;
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign scan_active = active_q;
    assign tap_state   = tap_q;

    // shared pin multiplexing
    logic [`PIN_N-1:0] pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
    logic              scan_side;

    // user side stays off until the fuse lane is known, so a dedicated pin never sees user drive
    assign scan_side = active_q || dedicated || !warm_q[1];                 // RULE5

    generate
        for (genvar i = 0; i < `PIN_N; i++) begin : g_pin
            always_comb begin
                if (scan_side) begin
                    pin_out_d[i] = (i == `PIN_TDO) ? tdo_q : 1'b0;      // RULE5
                    pin_oe_d[i]  = (i == `PIN_TDO) ? tdo_oe_q : 1'b0;
                end else begin
                    pin_out_d[i] = user_out[i];                         // RULE10
                    pin_oe_d[i]  = user_oe[i];
                end
            end
            assign user_in[i] = scan_side ? 1'b0 : pin_in[i];
        end
    endgenerate

    // probe multiplexing
    logic [1:0] probe_q, probe_d, probe_oe_q, probe_oe_d;

    always_comb begin
        if (debug_en) begin
            probe_d    = {probe_nodes[probe_sel_b], probe_nodes[probe_sel_a]};  // RULE7
            probe_oe_d = 2'h3;
        end else begin
            probe_d    = user_probe_out;                                        // RULE8
            probe_oe_d = user_probe_oe;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_q  <= '0;
            pin_oe_q   <= '0;
            probe_q    <= 2'h0;
            probe_oe_q <= 2'h0;
        end else if (clk_en) begin
            pin_out_q  <= pin_out_d;
            pin_oe_q   <= pin_oe_d;
            probe_q    <= probe_d;
            probe_oe_q <= probe_oe_d;
        end
    end

    assign pin_out     = pin_out_q;
    assign pin_oe      = pin_oe_q;
    assign probe_out_a = probe_q[0];
    assign probe_out_b = probe_q[1];
    assign probe_oe    = probe_oe_q;

    // helper: consecutive test clock rises with mode select high
    logic [2:0] hi_cnt_q, hi_cnt_d;

    always_comb begin
        hi_cnt_d = hi_cnt_q;
        if (clk_ok && tck_rise)
            hi_cnt_d = !tms_s ? 3'h0 : (hi_cnt_q == `CNT_MAX) ? hi_cnt_q : hi_cnt_q + 3'h1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            hi_cnt_q <= 3'h0;
        else if (clk_en)
            hi_cnt_q <= hi_cnt_d;
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    flex_entry_a: assert property (!dedicated && !active_q && !tms_s && trst_s |=> active_q) // RULE1
        else $error("flexible entry did not take the pins");
    hold_scan_a: assert property (!dedicated && active_q && tap_d != tap_reset && trst_s |=> active_q) // RULE2
        else $error("pins left scan use early");
    release_a: assert property (!dedicated && active_q && tap_q != tap_reset && tap_d == tap_reset
                                |=> !active_q ##1 (pin_oe == user_oe || !$stable(user_oe))) // RULE2
        else $error("pins not released at reset state");
    five_tck_a: assert property (trst_s && hi_cnt_q >= `RESET_TCKS |-> tap_q == tap_reset) // RULE3
        else $error("reset state not reached after five clocks");
    trst_hold_a: assert property (!trst_s |=> tap_q == tap_reset && !tdo_oe_q) // RULE4
        else $error("test reset did not hold reset state");
    dedicated_pins_a: assert property (dedicated && active_q |=> pin_oe[`PIN_TCK] == 1'b0
                                       && pin_oe[`PIN_TDI] == 1'b0 && user_in == '0) // RULE5
        else $error("dedicated pin given to user");
    warm_pins_a: assert property (!warm_q[1] |=> pin_oe[`PIN_TCK] == 1'b0 && pin_oe[`PIN_TDI] == 1'b0) // RULE5
        else $error("shared pin driven before fuse known");
    dedicated_tms_a: assert property (dedicated && trst_s && tap_q == tap_reset && tck_rise && !tms_s
                                      |=> tap_q == tap_idle && active_q) // RULE6
        else $error("dedicated mode select misbehaved");
    probe_follow_a: assert property (debug_en |=> probe_out_a == $past(probe_nodes[probe_sel_a])
                                     && probe_out_b == $past(probe_nodes[probe_sel_b]) && probe_oe == 2'h3) // RULE7
        else $error("probe did not follow node");
    probe_user_a: assert property (!debug_en |=> probe_oe == $past(user_probe_oe)
                                   && {probe_out_b, probe_out_a} == $past(user_probe_out)) // RULE8
        else $error("probe pin not user pin");
    user_ignore_a: assert property (!dedicated && !active_q && tms_s |=> tap_q == $past(tap_q)) // RULE9 RULE10
        else $error("scan logic saw a user pin");

    enter_scan_c: cover property (!active_q ##1 active_q);
    leave_scan_c: cover property (active_q ##1 !active_q);
    shift_c:      cover property (tap_q == tap_shift_dr && tdo_oe_q);
    probe_c:      cover property (debug_en ##1 !debug_en);

endmodule

`default_nettype wire

//--- design/pin_share_pkg.sv
// types for the test-pin sharing and probe block
package pin_share_pkg;

    // test state machine, one-hot
    typedef enum logic [15:0] {
        tap_reset    = 16'h0001,
        tap_idle     = 16'h0002,
        tap_sel_dr   = 16'h0004,
        tap_cap_dr   = 16'h0008,
        tap_shift_dr = 16'h0010,
        tap_ex1_dr   = 16'h0020,
        tap_pause_dr = 16'h0040,
        tap_ex2_dr   = 16'h0080,
        tap_upd_dr   = 16'h0100,
        tap_sel_ir   = 16'h0200,
        tap_cap_ir   = 16'h0400,
        tap_shift_ir = 16'h0800,
        tap_ex1_ir   = 16'h1000,
        tap_pause_ir = 16'h2000,
        tap_ex2_ir   = 16'h4000,
        tap_upd_ir   = 16'h8000
    } tap_state_t;

endpackage

//--- verification/jtag_pin_sharing_control_tb_top.sv
// self-checking bench for the test-pin sharing and probe block
`timescale 1ns/10ps
`default_nettype none

module jtag_pin_sharing_control_tb_top;
    import pin_share_pkg::*;

    typedef struct {logic de; logic [3:0] sa; logic [3:0] sb; logic [1:0] uo; logic [1:0] ue; logic [3:0] ex;} row_t;

    logic       core_clk = 1'b0;
    logic       rst_n, clk_en, fuse, debug_en, tdo_float = 1'b0;
    logic       t_tck, t_tms, t_tdi, t_trst_n, pa, pb;
    logic [2:0] pin_in, pin_out, pin_oe, user_out, user_oe, user_in;
    logic [1:0] probe_oe, up_out, up_oe;
    logic [3:0] sel_a, sel_b;
    logic       scan_active;
    tap_state_t tap_state;
    // internal nodes offered to the probes
    logic [15:0] nodes = 16'ha5c3;
    int         err_total = 0;
    int         n_checks  = 0;
    row_t       rows [5] = '{'{1, 0, 2, 0, 0, 4'hb}, '{1, 15, 9, 0, 0, 4'hb}, '{1, 4, 13, 0, 0, 4'h7},
                             '{0, 0, 0, 2, 1, 4'h5}, '{0, 0, 0, 1, 2, 4'ha}};

    // clock and a pattern on the undriven data-out lane
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) tdo_float <= ~tdo_float;

    // wire level from all drivers of each shared pin
    assign pin_in = {pin_oe[2] ? pin_out[2] : tdo_float, pin_oe[1] ? pin_out[1] : t_tdi, pin_oe[0] ? pin_out[0] : t_tck};

    jtag_tester jtag_tester_inst (.tck(t_tck), .tms(t_tms), .tdi(t_tdi), .trst_n(t_trst_n));

    pin_share_ctrl pin_share_ctrl_inst (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tms_pin(t_tms), .trst_n_pin(t_trst_n),
        .fuse_blown(fuse), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .user_out(user_out),
        .user_oe(user_oe), .user_in(user_in), .scan_active(scan_active), .tap_state(tap_state),
        .probe_nodes(nodes), .probe_sel_a(sel_a), .probe_sel_b(sel_b), .debug_en(debug_en),
        .user_probe_out(up_out), .user_probe_oe(up_oe), .probe_out_a(pa), .probe_out_b(pb), .probe_oe(probe_oe));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // one test clock, then settle on a falling core edge
    task automatic st(input logic m, input logic d);
        jtag_tester_inst.step(m, d);
        @(negedge core_clk);
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        fuse = 1'b0;
        debug_en = 1'b0;
        user_out = 3'h5;
        user_oe = 3'h7;
        {sel_a, sel_b, up_out, up_oe} = '0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            {debug_en, sel_a, sel_b, up_out, up_oe} = {rows[i].de, rows[i].sa, rows[i].sb, rows[i].uo, rows[i].ue};
            repeat (2) @(negedge core_clk);
            chk({12'h000, pa, pb, probe_oe}, {12'h000, rows[i].ex});
        end
        $display("probe table done");
        {debug_en, sel_a, sel_b} = {1'b1, 4'h0, 4'h2};
        repeat (2) @(negedge core_clk);
        clk_en = 1'b0;
        nodes = 16'h5a3c;
        repeat (2) @(negedge core_clk);
        chk({pa, pb}, 2'h2);
        clk_en = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({pa, pb}, 2'h1);
        $display("enable freeze and live probe done");
        chk(scan_active, 1'b0);
        chk(pin_oe, user_oe);
        chk(user_in, pin_in);
        st(1'b0, 1'b0);
        chk(scan_active, 1'b1);
        chk(pin_oe, 3'h0);
        chk(user_in, 3'h0);
        chk(tap_state, tap_idle);
        st(1'b1, 1'b0);
        st(1'b0, 1'b0);
        st(1'b0, 1'b1);
        chk(tap_state, tap_shift_dr);
        chk({pin_oe[2], pin_out[2]}, 2'h2);
        st(1'b0, 1'b1);
        chk(pin_oe[2] & pin_out[2], 1'b1);
        st(1'b0, 1'b0);
        chk(pin_out[2], 1'b0);
        repeat (4) st(1'b1, 1'b1);
        chk(scan_active, 1'b1);
        st(1'b1, 1'b1);
        chk(tap_state, tap_reset);
        @(negedge core_clk);
        chk({scan_active, pin_oe, pin_out}, {1'b0, user_oe, user_out});
        $display("flexible entry and release done");
        st(1'b0, 1'b0);
        jtag_tester_inst.trst_n = 1'b0;
        st(1'b0, 1'b0);
        chk({scan_active, tap_state}, {1'b0, tap_reset});
        jtag_tester_inst.tms = 1'b1;
        repeat (4) @(negedge core_clk);
        jtag_tester_inst.trst_n = 1'b1;
        $display("test reset done");
        repeat (4) @(negedge core_clk);
        jtag_tester_inst.tms = 1'b0;
        repeat (5) @(negedge core_clk);
        chk(scan_active, 1'b1);
        jtag_tester_inst.to_reset();
        @(negedge core_clk);
        chk({scan_active, pin_oe}, {1'b0, user_oe});
        $display("release from reset state done");
        rst_n = 1'b0;
        fuse = 1'b1;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({user_in, pin_oe}, 6'h00);
        repeat (3) @(negedge core_clk);
        chk({scan_active, pin_oe[1:0]}, 3'h4);
        jtag_tester_inst.to_reset();
        @(negedge core_clk);
        chk({scan_active, pin_oe[1:0]}, 3'h4);
        st(1'b0, 1'b0);
        chk(tap_state, tap_idle);
        st(1'b1, 1'b0);
        chk(tap_state, tap_sel_dr);
        $display("dedicated mode done");
        summarize();
    end

    // watchdog well beyond the expected run
    initial begin
        #100000;
        err_total++;
        $display("watchdog expired");
        summarize();
    end

endmodule
`default_nettype wire

//--- verification/jtag_tester.sv
// boundary-scan tester model driving the test pins
`timescale 1ns/10ps
`default_nettype none

module jtag_tester (
    // test pins
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);

    // idle: test clock parked low, reset released, mode select high
    initial begin
        tck    = 1'b0;
        tms    = 1'b1;
        tdi    = 1'b0;
        trst_n = 1'b1;
    end

    // one 125 ns test clock, then the clock stands still
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        #62.5 tck = 1'b0;
        #50;
    endtask

    // five clocks with mode select high reach the reset state
    task automatic to_reset();
        repeat (5) step(1'b1, 1'b0);
    endtask

endmodule
`default_nettype wire
